// ==== dtr_regs.vh ====
`ifndef DTR_REGS_VH
`define DTR_REGS_VH

// write leveling
`define DTR_LVL_FIRST_STROBE_WAIT 40
`define DTR_LVL_OUT_DELAY_PS 9000
`define DTR_LVL_OUT_DELAY_FAST_PS 7500
`define DTR_CLK_PERIOD_PS 8000

// dll-off write recovery
`define DTR_WR_MIN_CK 4
`define DTR_WR_MIN_PS 15000

// write recovery start offsets after write latency
`define DTR_WR_START_BL8 4
`define DTR_WR_START_BC4_FIXED 2

// latency field and counter widths
`define DTR_LAT_W 5
`define DTR_CNT_W 8

`endif

// ==== dtr_timing.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dtr_regs.vh"
// Contract
// - leveling feedback appears on data no later than 9 ns, or 7.5 ns at the fastest grade; the code takes 4 clocks after the sampled strobe in either grade.
// - with the dll off, read strobe timing refers to the edge cas+additive-1 clocks after READ.
// - the device accepts commands spaced by the rounded-up clock count of a time limit.
// - auto-precharge is held off until the minimum row active time since activate has passed.
// - with the dll off, write recovery is met after the larger of 4 clocks or 15 ns.
// - write recovery starts 4 clocks after write latency, or 2 for mode-fixed chop-four.
module dtr_timing #(
	parameter FAST_GRADE = 0,
	parameter ROW_ACTIVE_MIN_TIME = 5,
	parameter WRITE_RECOVERY_TIME = 2
) (
	input wire clk, // system clock
	input wire sys_rst, // sync reset, active high
	input wire clk_en, // freezes state when low
	input wire leveling_en, // write leveling mode
	input wire strobe_pin, // data strobe from pin
	input wire ck_level_pin, // memory clock level from pin
	input wire dll_off_mode, // dll disabled
	input wire burst_chop_fixed, // chop-four fixed by mode setting
	input wire [`DTR_LAT_W-1:0] cas_read_latency, // read latency
	input wire [`DTR_LAT_W-1:0] additive_latency, // additive latency
	input wire [`DTR_LAT_W-1:0] write_latency, // write latency
	input wire activate_cmd, // activate pulse
	input wire read_cmd, // read pulse
	input wire write_cmd, // write pulse
	input wire autoprecharge, // with read/write: auto-precharge
	output reg [7:0] dq_out, // leveling feedback data
	output reg dq_oe, // data pins driven
	output reg read_ref_edge, // strobe_to_clock_skew reference edge
	output reg precharge_issue, // internal precharge pulse
	output reg write_recovery_done // write recovery met
);

	// ---------------------------------------------------------------
	// derived counts
	// ---------------------------------------------------------------
	localparam OUT_PS = FAST_GRADE ? `DTR_LVL_OUT_DELAY_FAST_PS : `DTR_LVL_OUT_DELAY_PS;
	localparam OUT_CK_RAW = OUT_PS / `DTR_CLK_PERIOD_PS;
	localparam OUT_CK = (OUT_CK_RAW < 1) ? 1 : OUT_CK_RAW;
	localparam WR_CK_T = (`DTR_WR_MIN_PS + `DTR_CLK_PERIOD_PS - 1) / `DTR_CLK_PERIOD_PS;
	localparam DLL_WR_CK = (WR_CK_T > `DTR_WR_MIN_CK) ? WR_CK_T : `DTR_WR_MIN_CK;
	localparam CW = `DTR_CNT_W;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	reg [2:0] dqs_sync_q;
	reg [2:0] ck_sync_q;
	reg dqs_prev_q;
	wire dqs_stable = dqs_sync_q[1] == dqs_sync_q[2];
	wire ck_stable = ck_sync_q[1] == ck_sync_q[2];

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			dqs_sync_q <= 3'h0;
			ck_sync_q <= 3'h0;
			dqs_prev_q <= 1'b0;
		end
		else if (clk_en)
		begin
			dqs_sync_q <= {dqs_sync_q[1:0], strobe_pin};
			ck_sync_q <= {ck_sync_q[1:0], ck_level_pin};
			if (dqs_stable)
				dqs_prev_q <= dqs_sync_q[2];
		end
	end

	wire dqs_rise = dqs_stable && dqs_sync_q[2] && !dqs_prev_q;

	// ---------------------------------------------------------------
	// write leveling feedback
	// ---------------------------------------------------------------
	reg [CW-1:0] lvl_cnt_q;
	reg lvl_bit_q;
	reg lvl_pend_q;

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			lvl_cnt_q <= {CW{1'b0}};
			lvl_bit_q <= 1'b0;
			lvl_pend_q <= 1'b0;
			dq_out <= 8'h00;
			dq_oe <= 1'b0;
		end
		else if (clk_en)
		begin
			dq_oe <= leveling_en;
			if (!leveling_en)
			begin
				lvl_pend_q <= 1'b0;
				dq_out <= 8'h00;
			end
			else if (dqs_rise)
			begin
				lvl_bit_q <= ck_stable ? ck_sync_q[2] : lvl_bit_q;
				lvl_pend_q <= 1'b1;
				lvl_cnt_q <= {CW{1'b0}};
			end
			else if (lvl_pend_q)
			begin
				if (lvl_cnt_q == OUT_CK[CW-1:0] - 8'h01)
				begin
					dq_out <= {8{lvl_bit_q}};
					lvl_pend_q <= 1'b0;
				end
				lvl_cnt_q <= lvl_cnt_q + 8'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// dll-off read reference edge
	// ---------------------------------------------------------------
	reg [CW-1:0] rd_cnt_q;
	reg rd_act_q;
	wire [CW-1:0] rd_target = {3'h0, cas_read_latency} + {3'h0, additive_latency} - 8'h01;

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			rd_cnt_q <= {CW{1'b0}};
			rd_act_q <= 1'b0;
			read_ref_edge <= 1'b0;
		end
		else if (clk_en)
		begin
			read_ref_edge <= 1'b0;
			if (read_cmd && dll_off_mode)
			begin
				rd_act_q <= 1'b1;
				rd_cnt_q <= 8'h01;
			end
			else if (rd_act_q)
			begin
				if (rd_cnt_q == rd_target)
				begin
					read_ref_edge <= 1'b1;
					rd_act_q <= 1'b0;
				end
				rd_cnt_q <= rd_cnt_q + 8'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// row active timer and auto-precharge hold-off
	// ---------------------------------------------------------------
	reg [CW-1:0] ras_cnt_q;
	reg ap_pend_q;
	wire ras_met = ras_cnt_q >= ROW_ACTIVE_MIN_TIME[CW-1:0];

	// ---------------------------------------------------------------
	// write recovery
	// ---------------------------------------------------------------
	reg [CW-1:0] wr_cnt_q;
	reg wr_act_q;
	reg wr_rec_q;
	reg wr_ap_q;
	localparam [CW-1:0] WR_OFF_BC4 = `DTR_WR_START_BC4_FIXED;
	localparam [CW-1:0] WR_OFF_BL8 = `DTR_WR_START_BL8;
	wire [CW-1:0] wr_off = burst_chop_fixed ? WR_OFF_BC4 : WR_OFF_BL8;
	wire [CW-1:0] wr_start = {3'h0, write_latency} + wr_off;
	wire [CW-1:0] wr_need = dll_off_mode ? DLL_WR_CK[CW-1:0] : WRITE_RECOVERY_TIME[CW-1:0];
	// last cycle of a recovery, not overridden by a new write
	wire wr_end = !write_cmd && wr_act_q && wr_rec_q && (wr_cnt_q >= wr_need);

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			wr_cnt_q <= {CW{1'b0}};
			wr_act_q <= 1'b0;
			wr_rec_q <= 1'b0;
			wr_ap_q <= 1'b0;
			write_recovery_done <= 1'b1;
		end
		else if (clk_en)
		begin
			if (write_cmd)
			begin
				wr_act_q <= 1'b1;
				wr_rec_q <= 1'b0;
				wr_ap_q <= autoprecharge;
				wr_cnt_q <= 8'h01;
				write_recovery_done <= 1'b0;
			end
			else if (wr_act_q)
			begin
				wr_cnt_q <= wr_cnt_q + 8'h01;
				if (!wr_rec_q && wr_cnt_q == wr_start)
				begin
					wr_rec_q <= 1'b1;
					wr_cnt_q <= 8'h01;
				end
				else if (wr_rec_q && wr_cnt_q >= wr_need)
				begin
					wr_act_q <= 1'b0;
					wr_ap_q <= 1'b0; // hand auto-precharge over once
					write_recovery_done <= 1'b1;
				end
			end
		end
	end

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			ras_cnt_q <= {CW{1'b0}};
			ap_pend_q <= 1'b0;
			precharge_issue <= 1'b0;
		end
		else if (clk_en)
		begin
			precharge_issue <= 1'b0;
			if (activate_cmd)
				ras_cnt_q <= 8'h01;
			else if (!ras_met)
				ras_cnt_q <= ras_cnt_q + 8'h01;
			if ((read_cmd && autoprecharge) || (wr_end && wr_ap_q))
				ap_pend_q <= 1'b1;
			else if (ap_pend_q && ras_met)
			begin
				ap_pend_q <= 1'b0;
				precharge_issue <= 1'b1;
			end
		end
	end

endmodule // dtr_timing
`default_nettype wire

// ==== dtr_timing_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dtr_regs.vh"
module dtr_mon #(parameter ROW_ACTIVE_MIN_TIME = 5) (
	input wire clk, // clock
	input wire sys_rst, // reset
	input wire clk_en, // clock enable
	input wire leveling_en, // leveling
	input wire strobe_pin, // strobe
	input wire ck_level_pin, // ck level
	input wire dll_off_mode, // dll off
	input wire burst_chop_fixed, // fixed chop
	input wire [`DTR_LAT_W-1:0] cas_read_latency, // cl
	input wire [`DTR_LAT_W-1:0] additive_latency, // al
	input wire [`DTR_LAT_W-1:0] write_latency, // wl
	input wire activate_cmd, // act
	input wire read_cmd, // read
	input wire write_cmd, // write
	input wire [7:0] dq_out, // feedback
	input wire dq_oe, // drive
	input wire read_ref_edge, // ref
	input wire precharge_issue, // precharge
	input wire write_recovery_done // done
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// cycles since activate, saturating
	logic [7:0] act_q;
	always @(posedge clk)
		act_q <= (sys_rst || activate_cmd) ? 8'h00 : act_q + {7'h00, act_q != 8'hFF};
	a_oe_follow: assert property (!$past(sys_rst) && $past(clk_en) |-> dq_oe == $past(leveling_en))
		else $error("dq_oe not following leveling mode");
	a_dq_uniform: assert property (dq_out == {8{dq_out[0]}})
		else $error("dq_out bits differ");
	a_lvl_delay: assert property (leveling_en && $rose(strobe_pin) ##1 $stable(ck_level_pin)
		|-> ##4 dq_out == {8{$past(ck_level_pin, 5)}})
		else $error("leveling feedback late");
	a_ref_time: assert property (read_cmd && dll_off_mode && cas_read_latency == 5'h05
		&& additive_latency == 5'h00 |-> ##5 read_ref_edge)
		else $error("reference edge mistimed");
	a_ref_dll_on: assert property (read_cmd && !dll_off_mode |-> !read_ref_edge [*6])
		else $error("reference edge with dll on");
	a_pre_wait: assert property (precharge_issue |-> act_q >= ROW_ACTIVE_MIN_TIME)
		else $error("precharge before row active time");
	a_wr_bl8: assert property (write_cmd && dll_off_mode && write_latency == 5'h05 && !burst_chop_fixed
		|-> ##2 !write_recovery_done [*8] ##[2:5] write_recovery_done)
		else $error("dll off write recovery mistimed");
	a_wr_bc4: assert property (write_cmd && dll_off_mode && write_latency == 5'h05 && burst_chop_fixed
		|-> ##2 !write_recovery_done [*6] ##[2:5] write_recovery_done)
		else $error("fixed chop write recovery mistimed");
	a_wr_restart: assert property (write_cmd |-> ##[1:2] !write_recovery_done)
		else $error("write recovery not restarted");
endmodule // dtr_mon
bind dtr_timing dtr_mon #(.ROW_ACTIVE_MIN_TIME(ROW_ACTIVE_MIN_TIME)) i_dtr_mon (.*);
`default_nettype wire

// ==== dtr_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dtr_ctrl_model (
	input wire logic clk, // clock
	input wire logic lvl, // leveling mode
	output logic strobe // data strobe
);
	logic [15:0] cnt_q;
	// run far shorter than one refresh window: no refresh, no power-down
	always @(posedge clk)
	begin
		cnt_q <= lvl ? cnt_q + 16'h0001 : 16'h0000;
		strobe <= lvl && cnt_q >= 16'h0028 && cnt_q[3];
	end
endmodule // dtr_ctrl_model
`default_nettype wire

// ==== dtr_timing_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dtr_timing_tb;
	logic clk = 0, rst = 1, lvl = 0, ckl = 0, dll = 0, bcf = 0, act = 0, rd = 0, wr = 0, ap = 0;
	logic [4:0] cl = 5'h05, al = 5'h00, wl = 5'h05;
	logic ce = 1;
	wire [7:0] dq;
	wire oe, ref_e, pre, done, stb;
	int miscompares = 0, num_checks = 0, n;
	always #4 clk = ~clk;
	dtr_timing i_dtr_timing (.clk(clk), .sys_rst(rst), .clk_en(ce), .leveling_en(lvl),
		.strobe_pin(stb), .ck_level_pin(ckl), .dll_off_mode(dll), .burst_chop_fixed(bcf),
		.cas_read_latency(cl), .additive_latency(al), .write_latency(wl), .activate_cmd(act),
		.read_cmd(rd), .write_cmd(wr), .autoprecharge(ap), .dq_out(dq), .dq_oe(oe),
		.read_ref_edge(ref_e), .precharge_issue(pre), .write_recovery_done(done));
	dtr_ctrl_model i_dtr_ctrl_model (.clk(clk), .lvl(lvl), .strobe(stb));
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (e !== g)
		begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	// counts edges until done, ref_e or pre is high, or dq matches ckl with oe
	task wt(input int k);
		logic h;
		n = 0;
		h = 0;
		while (h !== 1'b1)
		begin
			@(posedge clk);
			#1;
			n++;
			h = (k == 0) ? done : (k == 1) ? ref_e : (k == 2) ? pre : (dq === {8{ckl}} && oe);
			if (n > 200)
			begin
				miscompares++;
				print_verdict;
			end
		end
	endtask
	task pulse(input int k);
		@(posedge clk);
		act <= k == 0;
		rd <= k == 1;
		wr <= k == 2;
		@(posedge clk);
		{act, rd, wr} <= 3'h0;
	endtask
	task t_lvl;
		@(posedge clk);
		lvl <= 1;
		ckl <= 1;
		wt(3);
		chk("lvl_dq", 8'hFF, dq);
		@(posedge clk);
		ckl <= 0;
		wt(3);
		chk("lvl_lat", 1, n <= 23);
		@(posedge clk);
		lvl <= 0;
		$display("leveling done");
	endtask
	task t_rd;
		dll <= 1;
		pulse(1);
		wt(1);
		chk("rd_ref", cl + al - 1, n);
		@(posedge clk);
		dll <= 0;
		pulse(1);
		n = 0;
		repeat (8)
		begin
			@(posedge clk);
			#1;
			n += (ref_e !== 1'b0);
		end
		chk("rd_dll_on", 0, n);
		$display("read reference done");
	endtask
	task t_wr(input logic d, input logic b);
		int e;
		e = wl + (b ? 2 : 4) + (d ? 4 : 2);
		@(posedge clk);
		dll <= d;
		bcf <= b;
		pulse(2);
		wt(0);
		chk("wr_done", e, n);
		$display("write recovery done");
	endtask
	task t_pre;
		@(posedge clk);
		ap <= 1;
		pulse(0);
		pulse(1);
		wt(2);
		chk("pre_wait", 3, n);
		@(posedge clk);
		ap <= 0;
		$display("precharge done");
	endtask
	task t_wr_ap;
		@(posedge clk);
		dll <= 0;
		bcf <= 0;
		ap <= 1;
		pulse(0);
		pulse(2);
		wt(2);
		chk("wr_ap_pre", wl + 4 + 2 + 1, n);
		@(posedge clk);
		ap <= 0;
		n = 0;
		repeat (8)
		begin
			@(posedge clk);
			#1;
			n += (pre !== 1'b0);
		end
		chk("wr_ap_once", 0, n);
		$display("write auto-precharge done");
	endtask
	task t_frz;
		@(posedge clk);
		dll <= 0;
		bcf <= 0;
		pulse(2);
		ce <= 0;
		repeat (20) @(posedge clk);
		chk("frz_hold", 0, done);
		ce <= 1;
		wt(0);
		chk("frz_done", wl + 4 + 2, n);
		pulse(2);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		@(posedge clk);
		#1;
		chk("rst_mid_done", 1, done);
		chk("rst_mid_oe", 0, oe);
		$display("freeze and reset done");
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		#1;
		chk("rst_done", 1, done);
		chk("rst_dq", 0, dq);
		chk("rst_oe", 0, oe);
		t_lvl;
		t_rd;
		t_wr(1, 0);
		t_wr(0, 0);
		t_wr(0, 1);
		t_wr(1, 1);
		t_pre;
		t_wr_ap;
		t_frz;
		print_verdict;
	end
endmodule // dtr_timing_tb
`default_nettype wire
